// ### design/monitor_result_consts.svh
// register offsets, reset values and field constants of the monitor result bank
`ifndef MONITOR_RESULT_CONSTS_SVH
`define MONITOR_RESULT_CONSTS_SVH
`define ADDR_STORED_PRESCALE   8'h30
`define ADDR_STORED_TRIM       8'h31
`define ADDR_RESERVED_HI       8'h32
`define ADDR_RESERVED_LO       8'h33
`define ADDR_AUX_LATEST_HI     8'h34
`define ADDR_AUX_LATEST_LO     8'h35
`define ADDR_AUX_LOWEST_HI     8'h36
`define ADDR_AUX_LOWEST_LO     8'h37
`define ADDR_AUX_HIGHEST_HI    8'h38
`define ADDR_AUX_HIGHEST_LO    8'h39
`define ADDR_SUPPLY_LATEST_HI  8'h3A
`define ADDR_SUPPLY_LATEST_LO  8'h3B
`define ADDR_SUPPLY_LOWEST_HI  8'h3C
`define ADDR_SUPPLY_LOWEST_LO  8'h3D
`define ADDR_SUPPLY_HIGHEST_HI 8'h3E
`define ADDR_SUPPLY_HIGHEST_LO 8'h3F
`define ADDR_SHUNT_LATEST_HI   8'h40
`define ADDR_SHUNT_LATEST_LO   8'h41
`define ADDR_SHUNT_LOWEST_HI   8'h42
`define ADDR_SHUNT_LOWEST_LO   8'h43
`define ADDR_SHUNT_HIGHEST_HI  8'h44
`define ADDR_SHUNT_HIGHEST_LO  8'h45
`define ADDR_POWER_LATEST_HI   8'h46
`define ADDR_POWER_LATEST_LO   8'h47
`define ADDR_POWER_LOWEST_HI   8'h48
`define ADDR_POWER_LOWEST_LO   8'h49
`define ADDR_POWER_HIGHEST_HI  8'h4A
`define ADDR_POWER_HIGHEST_LO  8'h4B
`define ADDR_USER_0            8'h4C
`define ADDR_USER_1            8'h4D
`define ADDR_USER_2            8'h4E
`define ADDR_USER_3            8'h4F
`define ADDR_RESULT_FIRST      8'h34
`define ADDR_RESULT_LAST       8'h4B
`define ADDR_USER_FIRST        8'h4C
`define ADDR_USER_LAST         8'h4F
`define RESET_STORED_PRESCALE  8'h08
`define RESET_STORED_TRIM      8'h96
`define RESET_USER_BYTE        8'h00
`define RESET_RESULT           16'h0000
`define RESET_LOWEST           16'hFFFF
`define RESET_HIGHEST          16'h0000
`define READ_ZERO              8'h00
`define BYTES_PER_QUANTITY     5'h06
`endif

// ### design/monitor_result_pkg.sv
// types shared by the monitor result register bank
package monitor_result_pkg;
  typedef enum logic [1:0] {
    Q_AUX    = 2'h0,
    Q_SUPPLY = 2'h1,
    Q_SHUNT  = 2'h2,
    Q_POWER  = 2'h3
  } quantity_type;

  typedef struct packed {
    logic [15:0] latest;
    logic [15:0] lowest;
    logic [15:0] highest;
  } track_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } reg_req_type;

  typedef struct packed {
    track_type [3:0] track;
    logic [7:0]      stored_prescale;
    logic [7:0]      stored_trim;
    logic [3:0][7:0] user_bytes;
    logic [7:0]      rdata;
    logic            rvalid;
  } bank_state_type;
endpackage

// ### design/monitor_result_register_bank.sv
// monitor result register bank: latest, lowest and highest results plus stored bytes
`timescale 1ns/1ps
`include "monitor_result_consts.svh"

module monitor_result_register_bank
  import monitor_result_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // register access from the serial host logic
  input  wire reg_req_type i_req,
  // converter results, one strobe per quantity
  input  wire logic [3:0]  i_result_valid,
  input  wire logic [63:0] i_result_data,
  // read answer
  output logic [7:0]       o_rdata,
  output logic             o_rvalid,
  // stored defaults for the prescaler and trim registers
  output logic [7:0]       o_stored_prescale,
  output logic [7:0]       o_stored_trim
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bank_state_type   state_reg;
  bank_state_type   state_next;
  logic [3:0][15:0] sample;
  logic [3:0]       below_lowest;
  logic [3:0]       above_highest;

  // ----------------------------------------------------------------
  // result compare, one lane per quantity
  // ----------------------------------------------------------------
  for (genvar q = 0; q < 4; q++) begin : g_lane
    assign sample[q]        = i_result_data[q*16 +: 16];
    // strict compares: an equal result leaves the tracked value alone
    assign below_lowest[q]  = sample[q] < state_reg.track[q].lowest;
    assign above_highest[q] = sample[q] > state_reg.track[q].highest;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next        = state_reg;
    state_next.rvalid = 1'b0;

    // new results: latest always, lowest/highest by compare
    for (int q = 0; q < 4; q++) begin
      if (i_result_valid[q]) begin
        state_next.track[q].latest = sample[q];
        if (below_lowest[q]) begin
          state_next.track[q].lowest = sample[q];
        end
        if (above_highest[q]) begin
          state_next.track[q].highest = sample[q];
        end
      end
    end

    // host writes come after results so a written byte takes hold
    if (i_req.wr) begin
      case (i_req.addr)
        `ADDR_STORED_PRESCALE: begin
          state_next.stored_prescale = i_req.wdata;
        end
        `ADDR_STORED_TRIM: begin
          state_next.stored_trim = i_req.wdata;
        end
        `ADDR_AUX_LATEST_HI: begin
          state_next.track[Q_AUX].latest[15:8] = i_req.wdata;
        end
        `ADDR_AUX_LATEST_LO: begin
          state_next.track[Q_AUX].latest[7:0] = i_req.wdata;
        end
        `ADDR_AUX_LOWEST_HI: begin
          state_next.track[Q_AUX].lowest[15:8] = i_req.wdata;
        end
        `ADDR_AUX_LOWEST_LO: begin
          state_next.track[Q_AUX].lowest[7:0] = i_req.wdata;
        end
        `ADDR_AUX_HIGHEST_HI: begin
          state_next.track[Q_AUX].highest[15:8] = i_req.wdata;
        end
        `ADDR_AUX_HIGHEST_LO: begin
          state_next.track[Q_AUX].highest[7:0] = i_req.wdata;
        end
        `ADDR_SUPPLY_LATEST_HI: begin
          state_next.track[Q_SUPPLY].latest[15:8] = i_req.wdata;
        end
        `ADDR_SUPPLY_LATEST_LO: begin
          state_next.track[Q_SUPPLY].latest[7:0] = i_req.wdata;
        end
        `ADDR_SUPPLY_LOWEST_HI: begin
          state_next.track[Q_SUPPLY].lowest[15:8] = i_req.wdata;
        end
        `ADDR_SUPPLY_LOWEST_LO: begin
          state_next.track[Q_SUPPLY].lowest[7:0] = i_req.wdata;
        end
        `ADDR_SUPPLY_HIGHEST_HI: begin
          state_next.track[Q_SUPPLY].highest[15:8] = i_req.wdata;
        end
        `ADDR_SUPPLY_HIGHEST_LO: begin
          state_next.track[Q_SUPPLY].highest[7:0] = i_req.wdata;
        end
        `ADDR_SHUNT_LATEST_HI: begin
          state_next.track[Q_SHUNT].latest[15:8] = i_req.wdata;
        end
        `ADDR_SHUNT_LATEST_LO: begin
          state_next.track[Q_SHUNT].latest[7:0] = i_req.wdata;
        end
        `ADDR_SHUNT_LOWEST_HI: begin
          state_next.track[Q_SHUNT].lowest[15:8] = i_req.wdata;
        end
        `ADDR_SHUNT_LOWEST_LO: begin
          state_next.track[Q_SHUNT].lowest[7:0] = i_req.wdata;
        end
        `ADDR_SHUNT_HIGHEST_HI: begin
          state_next.track[Q_SHUNT].highest[15:8] = i_req.wdata;
        end
        `ADDR_SHUNT_HIGHEST_LO: begin
          state_next.track[Q_SHUNT].highest[7:0] = i_req.wdata;
        end
        `ADDR_POWER_LATEST_HI: begin
          state_next.track[Q_POWER].latest[15:8] = i_req.wdata;
        end
        `ADDR_POWER_LATEST_LO: begin
          state_next.track[Q_POWER].latest[7:0] = i_req.wdata;
        end
        `ADDR_POWER_LOWEST_HI: begin
          state_next.track[Q_POWER].lowest[15:8] = i_req.wdata;
        end
        `ADDR_POWER_LOWEST_LO: begin
          state_next.track[Q_POWER].lowest[7:0] = i_req.wdata;
        end
        `ADDR_POWER_HIGHEST_HI: begin
          state_next.track[Q_POWER].highest[15:8] = i_req.wdata;
        end
        `ADDR_POWER_HIGHEST_LO: begin
          state_next.track[Q_POWER].highest[7:0] = i_req.wdata;
        end
        `ADDR_USER_0: begin
          state_next.user_bytes[0] = i_req.wdata;
        end
        `ADDR_USER_1: begin
          state_next.user_bytes[1] = i_req.wdata;
        end
        `ADDR_USER_2: begin
          state_next.user_bytes[2] = i_req.wdata;
        end
        `ADDR_USER_3: begin
          state_next.user_bytes[3] = i_req.wdata;
        end
        default: begin
          // reserved bytes and unmapped addresses drop the write
        end
      endcase
    end

    // read answer one cycle after the request, upper byte at lower address
    if (i_req.rd) begin
      state_next.rvalid = 1'b1;
      case (i_req.addr)
        `ADDR_STORED_PRESCALE: begin
          state_next.rdata = state_reg.stored_prescale;
        end
        `ADDR_STORED_TRIM: begin
          state_next.rdata = state_reg.stored_trim;
        end
        `ADDR_RESERVED_HI: begin
          state_next.rdata = `READ_ZERO;
        end
        `ADDR_RESERVED_LO: begin
          state_next.rdata = `READ_ZERO;
        end
        `ADDR_AUX_LATEST_HI: begin
          state_next.rdata = state_reg.track[Q_AUX].latest[15:8];
        end
        `ADDR_AUX_LATEST_LO: begin
          state_next.rdata = state_reg.track[Q_AUX].latest[7:0];
        end
        `ADDR_AUX_LOWEST_HI: begin
          state_next.rdata = state_reg.track[Q_AUX].lowest[15:8];
        end
        `ADDR_AUX_LOWEST_LO: begin
          state_next.rdata = state_reg.track[Q_AUX].lowest[7:0];
        end
        `ADDR_AUX_HIGHEST_HI: begin
          state_next.rdata = state_reg.track[Q_AUX].highest[15:8];
        end
        `ADDR_AUX_HIGHEST_LO: begin
          state_next.rdata = state_reg.track[Q_AUX].highest[7:0];
        end
        `ADDR_SUPPLY_LATEST_HI: begin
          state_next.rdata = state_reg.track[Q_SUPPLY].latest[15:8];
        end
        `ADDR_SUPPLY_LATEST_LO: begin
          state_next.rdata = state_reg.track[Q_SUPPLY].latest[7:0];
        end
        `ADDR_SUPPLY_LOWEST_HI: begin
          state_next.rdata = state_reg.track[Q_SUPPLY].lowest[15:8];
        end
        `ADDR_SUPPLY_LOWEST_LO: begin
          state_next.rdata = state_reg.track[Q_SUPPLY].lowest[7:0];
        end
        `ADDR_SUPPLY_HIGHEST_HI: begin
          state_next.rdata = state_reg.track[Q_SUPPLY].highest[15:8];
        end
        `ADDR_SUPPLY_HIGHEST_LO: begin
          state_next.rdata = state_reg.track[Q_SUPPLY].highest[7:0];
        end
        `ADDR_SHUNT_LATEST_HI: begin
          state_next.rdata = state_reg.track[Q_SHUNT].latest[15:8];
        end
        `ADDR_SHUNT_LATEST_LO: begin
          state_next.rdata = state_reg.track[Q_SHUNT].latest[7:0];
        end
        `ADDR_SHUNT_LOWEST_HI: begin
          state_next.rdata = state_reg.track[Q_SHUNT].lowest[15:8];
        end
        `ADDR_SHUNT_LOWEST_LO: begin
          state_next.rdata = state_reg.track[Q_SHUNT].lowest[7:0];
        end
        `ADDR_SHUNT_HIGHEST_HI: begin
          state_next.rdata = state_reg.track[Q_SHUNT].highest[15:8];
        end
        `ADDR_SHUNT_HIGHEST_LO: begin
          state_next.rdata = state_reg.track[Q_SHUNT].highest[7:0];
        end
        `ADDR_POWER_LATEST_HI: begin
          state_next.rdata = state_reg.track[Q_POWER].latest[15:8];
        end
        `ADDR_POWER_LATEST_LO: begin
          state_next.rdata = state_reg.track[Q_POWER].latest[7:0];
        end
        `ADDR_POWER_LOWEST_HI: begin
          state_next.rdata = state_reg.track[Q_POWER].lowest[15:8];
        end
        `ADDR_POWER_LOWEST_LO: begin
          state_next.rdata = state_reg.track[Q_POWER].lowest[7:0];
        end
        `ADDR_POWER_HIGHEST_HI: begin
          state_next.rdata = state_reg.track[Q_POWER].highest[15:8];
        end
        `ADDR_POWER_HIGHEST_LO: begin
          state_next.rdata = state_reg.track[Q_POWER].highest[7:0];
        end
        `ADDR_USER_0: begin
          state_next.rdata = state_reg.user_bytes[0];
        end
        `ADDR_USER_1: begin
          state_next.rdata = state_reg.user_bytes[1];
        end
        `ADDR_USER_2: begin
          state_next.rdata = state_reg.user_bytes[2];
        end
        `ADDR_USER_3: begin
          state_next.rdata = state_reg.user_bytes[3];
        end
        default: begin
          state_next.rdata = `READ_ZERO;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int q = 0; q < 4; q++) begin
        state_reg.track[q].latest  <= `RESET_RESULT;
        state_reg.track[q].lowest  <= `RESET_LOWEST;
        state_reg.track[q].highest <= `RESET_HIGHEST;
      end
      state_reg.stored_prescale <= `RESET_STORED_PRESCALE;
      state_reg.stored_trim     <= `RESET_STORED_TRIM;
      state_reg.user_bytes      <= {4{`RESET_USER_BYTE}};
      state_reg.rdata           <= `READ_ZERO;
      state_reg.rvalid          <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata           = state_reg.rdata;
  assign o_rvalid          = state_reg.rvalid;
  assign o_stored_prescale = state_reg.stored_prescale;
  assign o_stored_trim     = state_reg.stored_trim;

endmodule // monitor_result_register_bank

// ### bench/monitor_host_model.sv
// host side model issuing byte reads and writes
`timescale 1ns/1ps
module monitor_host_model
  import monitor_result_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output reg_req_type     o_req
);
  initial o_req = '0;
  task automatic access(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge i_clk);
    o_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge i_clk);
    // idle request shows no stale address or data
    o_req = '{wr: 0, rd: 0, addr: ~a, wdata: ~d};
    q = i_rdata;
  endtask
endmodule // monitor_host_model

// ### bench/monitor_result_register_bank_props.sv
// port assertions of the monitor result register bank
`timescale 1ns/1ps
module monitor_result_register_bank_props
  import monitor_result_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire reg_req_type i_req,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_rvalid,
  input wire logic [7:0]  o_stored_prescale,
  input wire logic [7:0]  o_stored_trim
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_rd(logic [7:0] a); i_req.rd && i_req.addr == a; endsequence
  sequence s_wr(logic [7:0] a); i_req.wr && i_req.addr == a; endsequence
  a_read_answered: assert property (i_req.rd |=> o_rvalid) else $error("no answer");
  a_no_stray: assert property (!i_req.rd |=> !o_rvalid) else $error("stray answer");
  a_rdata_held: assert property (!i_req.rd |=> $stable(o_rdata)) else $error("rdata moved");
  a_reserved_zero: assert property (s_rd(8'h32) |=> o_rdata == 8'h00) else $error("rsvd");
  a_reserved_lo: assert property (s_rd(8'h33) |=> o_rdata == 8'h00) else $error("rsvd lo");
  a_prescale_wr: assert property (s_wr(8'h30) |=> o_stored_prescale == $past(i_req.wdata))
    else $error("prescale write");
  a_trim_wr: assert property (s_wr(8'h31) |=> o_stored_trim == $past(i_req.wdata))
    else $error("trim write");
  a_prescale_keep: assert property (!i_req.wr |=> $stable(o_stored_prescale)) else $error("p");
  a_trim_keep: assert property (!i_req.wr |=> $stable(o_stored_trim)) else $error("trim moved");
  a_prescale_rd: assert property (s_rd(8'h30) |=> o_rdata == $past(o_stored_prescale))
    else $error("prescale read");
  a_trim_rd: assert property (s_rd(8'h31) |=> o_rdata == $past(o_stored_trim)) else $error("t");
endmodule // monitor_result_register_bank_props

// ### bench/tb_monitor_result_register_bank.sv
// self-checking bench for the monitor result register bank
`timescale 1ns/1ps
module tb_monitor_result_register_bank
  import monitor_result_pkg::*;
;
  logic        i_clk = 0;
  logic        i_resetn = 0;
  reg_req_type i_req;
  logic [3:0]  i_result_valid = '0;
  logic [63:0] i_result_data = '0;
  logic [7:0]  o_rdata, o_stored_prescale, o_stored_trim, q;
  logic        o_rvalid;
  logic [7:0]  m [8'h30:8'h4F];
  int          bad_count = 0, comparisons = 0, cycles = 0;
  always #5 i_clk = ~i_clk;
  monitor_host_model i_monitor_host_model (.i_clk(i_clk), .i_rdata(o_rdata), .o_req(i_req));
  monitor_result_register_bank i_monitor_result_register_bank (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_req(i_req), .i_result_valid(i_result_valid),
    .i_result_data(i_result_data), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_stored_prescale(o_stored_prescale), .o_stored_trim(o_stored_trim));
  task automatic give_verdict();
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] a, e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s %h exp %h got %h", n, a, e, g);
    end
  endtask
  task automatic init_model();
    for (int a = 8'h34; a < 8'h4C; a++) m[a] = ((a - 8'h34) % 6 inside {2, 3}) ? 8'hFF : 8'h00;
    m[8'h30] = 8'h08;
    m[8'h31] = 8'h96;
    for (int a = 8'h4C; a < 8'h50; a++) m[a] = 8'h00;
  endtask
  function automatic logic mapped(input logic [7:0] a);
    return a inside {[8'h30:8'h31], [8'h34:8'h4F]};
  endfunction
  task automatic op(input int k, input logic [7:0] a, d);
    logic [7:0]  b;
    logic [15:0] v;
    b = 8'h34 + 8'(6 * a[1:0]);
    if (k == 0) begin
      i_monitor_host_model.access(1, a, d, q);
      if (mapped(a)) m[a] = d;
    end else if (k == 1) begin
      @(negedge i_clk);
      i_result_data = {$urandom, $urandom};
      i_result_valid = 4'h1 << a[1:0];
      v = i_result_data[16*a[1:0] +: 16];
      {m[b], m[b+1]} = v;
      if (v < {m[b+2], m[b+3]}) {m[b+2], m[b+3]} = v;
      if (v > {m[b+4], m[b+5]}) {m[b+4], m[b+5]} = v;
      @(negedge i_clk);
      i_result_valid = '0;
    end else begin
      i_monitor_host_model.access(0, a, d, q);
      chk("byte", a, mapped(a) ? m[a] : 8'h00, q);
    end
    chk("valid", a, {7'h00, k == 2}, {7'h00, o_rvalid});
    chk("prescale", 8'h30, m[8'h30], o_stored_prescale);
    chk("trim", 8'h31, m[8'h31], o_stored_trim);
  endtask
  task automatic random_ops(input int n);
    repeat (n) op($urandom % 3, 8'(8'h30 + $urandom % 36), 8'($urandom));
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(80298));
    init_model();
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
    i_resetn = 1;
    // reset values, reserved and unmapped bytes, then writes to reserved bytes
    for (int a = 8'h30; a < 8'h54; a++) op(2, 8'(a), 8'h00);
    op(0, 8'h32, 8'hA5);
    op(0, 8'h33, 8'h5A);
    op(2, 8'h32, 8'h00);
    op(2, 8'h33, 8'h00);
    random_ops(1500);
    // reset in mid-run returns every byte to its reset value
    @(negedge i_clk);
    i_resetn = 0;
    init_model();
    repeat (2) @(negedge i_clk);
    i_resetn = 1;
    for (int a = 8'h30; a < 8'h50; a++) op(2, 8'(a), 8'h00);
    random_ops(1500);
    give_verdict();
  end
endmodule // tb_monitor_result_register_bank
bind monitor_result_register_bank monitor_result_register_bank_props i_props (.i_clk(i_clk),
  .i_resetn(i_resetn), .i_req(i_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .o_stored_prescale(o_stored_prescale), .o_stored_trim(o_stored_trim));
